// File: spmc_pkg.sv
`default_nettype none
// shared constants for the scanner power and mode controller
package spmc_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_IDLE_S    = 12'h004;
    localparam logic [11:0] ADDR_OFF_S     = 12'h008;
    localparam logic [11:0] ADDR_STATUS    = 12'h00C;
    localparam logic [11:0] ADDR_STEP_RES  = 12'h010;
    // ctrl fields
    localparam int CTRL_DISINF_EN = 0;
    localparam int CTRL_SERVICE   = 1;
    localparam int CTRL_XFER_DONE = 2;
    localparam int CTRL_WAKE_CMD  = 3;
    // reset values
    localparam logic [15:0] IDLE_S_RST = 16'h012C;
    localparam logic [15:0] OFF_S_RST  = 16'h0E10;
    localparam logic [15:0] UV_S_RST   = 16'h003C;
    // self-test step count and step indices
    localparam int ST_STEPS = 10;
    localparam int ST_HV    = 4;
    localparam int ST_ERASE = 5;
    localparam int ST_DAC   = 6;
    localparam int ST_UV    = 8;
    // timing
    localparam longint CLK_HZ      = 100000000;
    localparam longint KEY_LONG_MS = 1000;
    localparam longint KEY_ABORT_MS = 4000;
    localparam longint KEY_LONG_CYC  = KEY_LONG_MS * CLK_HZ / 1000;
    localparam longint KEY_ABORT_CYC = KEY_ABORT_MS * CLK_HZ / 1000;
    // states
    typedef enum logic [7:0] {
        ST_OFF     = 8'h01,
        ST_TEST    = 8'h02,
        ST_WAITLNK = 8'h04,
        ST_READY   = 8'h08,
        ST_STANDBY = 8'h10,
        ST_UVCYC   = 8'h20,
        ST_ERROR   = 8'h40,
        ST_FAIL    = 8'h80
    } spmc_state_t;
endpackage : spmc_pkg
`default_nettype wire

// File: spmc_top.sv
// Behaviour
// - standby after configurable idle seconds
// - proximity or start key wakes standby
// - short power press in ready beeps
// - ready powers off after one-second hold
// - any power press in standby powers off
// - auto off after standby shutdown interval
// - uv cycle before hold-off in ready or auto off in standby, show remaining
// - power held 4 s aborts uv, off
// - start held 4 s aborts uv, resume
// - lost link with image: indicate, carrier in
// - pending image blocks off, beeps on press; code still powers off from the uv cycle
// - self-test steps run in fixed order
// - hv test and dac need safety closed
// - safety open after erase test: halt error
// - safety closed after erase lamp continues
// - failure shows error, else ready after link
// - laser and uv blocked with cover off
// - hv lamp follows hv supply
// - red lamp while logic in reset
// - three link-speed lamps from phy
// - service mode ignores local keys, and proximity in standby
// - uv lamp fit by loop, current readback
// - service command in standby only wakes
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module spmc_top #(
    parameter longint KEY_LONG_CYC  = spmc_pkg::KEY_LONG_CYC,
    parameter longint KEY_ABORT_CYC = spmc_pkg::KEY_ABORT_CYC,
    parameter longint SEC_CYC       = spmc_pkg::CLK_HZ
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,

    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,

    // keys, sensors, host
    input  wire logic        power_key,
    input  wire logic        start_key,
    input  wire logic        proximity,
    input  wire logic        safety_closed,
    input  wire logic        host_link_up,
    input  wire logic        image_pending,

    // self-test handshake: step request, done and pass
    output logic [3:0]       test_step,
    output logic             test_req,
    input  wire logic        test_done,
    input  wire logic        test_pass,

    // actuators and display
    output logic             unit_power_on,
    output logic             beep,
    output logic             carrier_in,
    output logic             pending_indication,
    output logic             error_display,
    output logic [15:0]      uv_remaining_s,
    input  wire logic        laser_req,
    input  wire logic        uv_req,
    output logic             laser_enable,
    output logic             disinfection_lamp,
    input  wire logic        uv_loop_closed,
    input  wire logic        uv_current_ok,
    output logic             uv_fault,

    // lamps
    input  wire logic        hv_supply_on,
    input  wire logic        fpga_in_reset,
    input  wire logic        phy_link,
    input  wire logic [1:0]  phy_speed,
    output logic             high_voltage_lamp,
    output logic             logic_reset_lamp,
    output logic             link_slow_lamp,
    output logic             link_fast_lamp,
    output logic             link_gigabit_lamp
);
    spmc_pkg::spmc_state_t state_q;
    logic [15:0] idle_s_q, off_s_q, uv_s_q, sec_cnt_q, timer_s_q;
    logic [31:0] tick_q;
    logic [31:0] pkey_cnt_q, skey_cnt_q;
    logic        pkey_q, skey_q, disinf_en_q, service_q, scanned_q, wake_cmd_q;
    logic [spmc_pkg::ST_STEPS-1:0] step_res_q;
    logic        sec_tick, wr, rd, local_ok, pkey_fall, pkey_long, pkey_abort, skey_abort;
    logic        safe_cover, hold_image;

    // ------------------------------------------------------------
    // apb slave: zero wait, unmapped reads zero and flag error
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == spmc_pkg::ADDR_CTRL) || (a == spmc_pkg::ADDR_IDLE_S) ||
                 (a == spmc_pkg::ADDR_OFF_S) || (a == spmc_pkg::ADDR_STATUS) ||
                 (a == spmc_pkg::ADDR_STEP_RES);
    endfunction : mapped

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    // read data registered in setup so it is valid in the access phase
    always_ff @(posedge clk)
    begin
        if (srst)
            prdata <= 32'h0000_0000;
        else if (rd)
            unique case (paddr)
                spmc_pkg::ADDR_CTRL:     prdata <= {28'h0, wake_cmd_q, 1'b0, service_q, disinf_en_q};
                spmc_pkg::ADDR_IDLE_S:   prdata <= {16'h0, idle_s_q};
                spmc_pkg::ADDR_OFF_S:    prdata <= {16'h0, off_s_q};
                spmc_pkg::ADDR_STATUS:   prdata <= {8'h0, uv_remaining_s, state_q};
                spmc_pkg::ADDR_STEP_RES: prdata <= {22'h0, step_res_q};
                default:                 prdata <= 32'h0000_0000;
            endcase
    end

    // configuration registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            idle_s_q    <= spmc_pkg::IDLE_S_RST;
            off_s_q     <= spmc_pkg::OFF_S_RST;
            disinf_en_q <= 1'b1;
            service_q   <= 1'b0;
        end
        else if (wr && state_q != spmc_pkg::ST_STANDBY) // a write in standby only wakes
        begin
            if (paddr == spmc_pkg::ADDR_IDLE_S)
                idle_s_q <= pwdata[15:0];               // host sets idle seconds
            if (paddr == spmc_pkg::ADDR_OFF_S)
                off_s_q <= pwdata[15:0];
            if (paddr == spmc_pkg::ADDR_CTRL)
            begin
                disinf_en_q <= pwdata[spmc_pkg::CTRL_DISINF_EN];
                service_q   <= pwdata[spmc_pkg::CTRL_SERVICE]; // only the terminal enters service
            end
        end
    end

    // wake request from a bus write during standby, consumed by the fsm
    always_ff @(posedge clk)
    begin
        if (srst)
            wake_cmd_q <= 1'b0;
        else
            wake_cmd_q <= wr && state_q == spmc_pkg::ST_STANDBY;
    end
    // uv cycle length is fixed
    assign uv_s_q = spmc_pkg::UV_S_RST;

    // ------------------------------------------------------------
    // key hold timers and one-second tick
    // ------------------------------------------------------------
    assign local_ok = !service_q; // local keys ignored in service; proximity gated in standby only
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pkey_q     <= 1'b0;
            skey_q     <= 1'b0;
            pkey_cnt_q <= 32'h0;
            skey_cnt_q <= 32'h0;
        end
        else
        begin
            pkey_q <= power_key && local_ok;
            skey_q <= start_key && local_ok;
            // counter restarts on every new press
            pkey_cnt_q <= (power_key && local_ok && pkey_q) ? pkey_cnt_q + 32'h1 : 32'h0;
            skey_cnt_q <= (start_key && local_ok && skey_q) ? skey_cnt_q + 32'h1 : 32'h0;
        end
    end

    assign pkey_fall  = pkey_q && !(power_key && local_ok);
    assign pkey_long  = pkey_cnt_q >= KEY_LONG_CYC[31:0];
    assign pkey_abort = pkey_cnt_q >= KEY_ABORT_CYC[31:0];
    assign skey_abort = skey_cnt_q >= KEY_ABORT_CYC[31:0];

    always_ff @(posedge clk)
    begin
        if (srst)
            tick_q <= 32'h0;
        else
            tick_q <= (tick_q >= SEC_CYC[31:0] - 32'h1) ? 32'h0 : tick_q + 32'h1;
    end
    assign sec_tick = tick_q == SEC_CYC[31:0] - 32'h1;

    // ------------------------------------------------------------
    // power and mode state machine
    // ------------------------------------------------------------
    assign hold_image = image_pending; // untransferred image blocks power-off from ready and standby
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q    <= spmc_pkg::ST_OFF;
            test_step  <= 4'h0;
            step_res_q <= '0;
            timer_s_q  <= 16'h0;
            scanned_q  <= 1'b0;
        end
        else
        begin
            if (image_pending)
                scanned_q <= 1'b1;
            if (sec_tick)
                timer_s_q <= timer_s_q + 16'h1;
            unique case (state_q)
                spmc_pkg::ST_OFF:
                    // a key still held from power-off must not restart
                    if (pkey_q && pkey_cnt_q == 32'h0)
                    begin
                        state_q   <= spmc_pkg::ST_TEST;
                        test_step <= 4'h0;
                    end

                spmc_pkg::ST_TEST:
                    if (test_step == 4'(spmc_pkg::ST_ERASE + 1) && !safety_closed)
                        state_q <= spmc_pkg::ST_ERROR;      // halt, restart only
                    else if (test_done || ((test_step == 4'(spmc_pkg::ST_HV) ||
                             test_step == 4'(spmc_pkg::ST_DAC)) && !safety_closed))
                    begin
                        // step skipped when safety open counts as pass; late close still passes
                        step_res_q[test_step] <= test_done ? test_pass : 1'b1;
                        if (test_step == 4'(spmc_pkg::ST_STEPS - 1))
                            state_q <= spmc_pkg::ST_WAITLNK;
                        else
                            test_step <= test_step + 4'h1; // fixed order
                    end

                spmc_pkg::ST_WAITLNK:
                    if (!(&step_res_q))
                        state_q <= spmc_pkg::ST_FAIL;
                    else if (host_link_up)
                    begin
                        state_q   <= spmc_pkg::ST_READY;
                        timer_s_q <= 16'h0;
                    end

                spmc_pkg::ST_READY:
                begin
                    if (pkey_q || skey_q || proximity || wr)
                        timer_s_q <= 16'h0;
                    if (pkey_long && !hold_image)
                    begin
                        // scanned plates get the uv cycle first
                        state_q   <= (disinf_en_q && scanned_q) ? spmc_pkg::ST_UVCYC : spmc_pkg::ST_OFF;
                        timer_s_q <= 16'h0;
                    end
                    else if (timer_s_q >= idle_s_q && !(pkey_q || skey_q))
                    begin
                        state_q   <= spmc_pkg::ST_STANDBY;
                        timer_s_q <= 16'h0;
                    end
                end

                spmc_pkg::ST_STANDBY:
                    if (pkey_q && !hold_image)
                        state_q <= spmc_pkg::ST_OFF;
                    else if (skey_q || (proximity && local_ok) || wake_cmd_q)
                    begin
                        state_q   <= spmc_pkg::ST_READY;
                        timer_s_q <= 16'h0;
                    end
                    else if (timer_s_q >= off_s_q && !hold_image)
                    begin
                        timer_s_q <= 16'h0;
                        state_q   <= (disinf_en_q && scanned_q) ? spmc_pkg::ST_UVCYC : spmc_pkg::ST_OFF;
                    end

                spmc_pkg::ST_UVCYC:
                    if (pkey_abort || timer_s_q >= uv_s_q)
                        state_q <= spmc_pkg::ST_OFF;
                    else if (skey_abort)
                    begin
                        state_q   <= spmc_pkg::ST_READY;
                        timer_s_q <= 16'h0;
                        scanned_q <= 1'b0;
                    end

                spmc_pkg::ST_ERROR: ;
                spmc_pkg::ST_FAIL: ;
                default: state_q <= spmc_pkg::ST_ERROR;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign safe_cover = safety_closed;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            beep               <= 1'b0;
            unit_power_on      <= 1'b0;
            carrier_in         <= 1'b0;
            pending_indication <= 1'b0;
            error_display      <= 1'b0;
            uv_remaining_s     <= 16'h0;
            laser_enable       <= 1'b0;
            disinfection_lamp  <= 1'b0;
            uv_fault           <= 1'b0;
            test_req           <= 1'b0;
        end
        else
        begin
            // short press in ready beeps; pending image beeps while held
            beep <= (state_q == spmc_pkg::ST_READY && pkey_fall && !pkey_long) ||
                    (hold_image && pkey_q);
            unit_power_on <= state_q != spmc_pkg::ST_OFF;
            pending_indication <= image_pending && !host_link_up;
            carrier_in         <= image_pending && !host_link_up;
            error_display <= state_q == spmc_pkg::ST_ERROR || state_q == spmc_pkg::ST_FAIL;
            uv_remaining_s <= (state_q == spmc_pkg::ST_UVCYC) ? uv_s_q - timer_s_q : 16'h0;
            laser_enable <= laser_req && safe_cover;
            disinfection_lamp <= safe_cover && uv_loop_closed &&
                                 (state_q == spmc_pkg::ST_UVCYC || uv_req ||
                                  (state_q == spmc_pkg::ST_TEST && test_step == 4'(spmc_pkg::ST_UV)));
            uv_fault <= !uv_loop_closed || (disinfection_lamp && !uv_current_ok);
            test_req <= state_q == spmc_pkg::ST_TEST;
        end
    end

    // lamps follow their sources directly
    assign high_voltage_lamp = hv_supply_on;
    assign logic_reset_lamp  = fpga_in_reset || srst;
    assign link_slow_lamp    = phy_link && phy_speed == 2'h0;
    assign link_fast_lamp    = phy_link && phy_speed == 2'h1;
    assign link_gigabit_lamp = phy_link && phy_speed == 2'h2;
endmodule : spmc_top
`default_nettype wire

// File: spmc_properties.sv
`timescale 1ns/10ps
`default_nettype none
module spmc_properties (
    // clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // sensed inputs
    input wire logic       power_key,
    input wire logic       image_pending,
    input wire logic       host_link_up,
    input wire logic       safety_closed,
    input wire logic       hv_supply_on,
    input wire logic       fpga_in_reset,
    input wire logic       phy_link,
    input wire logic [1:0] phy_speed,
    input wire logic       test_done,
    // design outputs
    input wire logic       test_req,
    input wire logic [3:0] test_step,
    input wire logic       unit_power_on,
    input wire logic       beep,
    input wire logic       carrier_in,
    input wire logic       pending_indication,
    input wire logic       error_display,
    input wire logic       laser_enable,
    input wire logic       disinfection_lamp,
    input wire logic       high_voltage_lamp,
    input wire logic       logic_reset_lamp,
    input wire logic       link_slow_lamp,
    input wire logic       link_fast_lamp,
    input wire logic       link_gigabit_lamp
);
    // ------------------------------------------------------------
    // one clock domain, reset masks everything
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    hv_lamp_follows_a: assert property (high_voltage_lamp == hv_supply_on)
        else $error("hv lamp differs from supply");
    reset_lamp_follows_a: assert property (logic_reset_lamp == fpga_in_reset)
        else $error("reset lamp differs from logic reset");
    slow_link_lamp_a: assert property (link_slow_lamp == (phy_link && phy_speed == 2'h0))
        else $error("slow link lamp wrong");
    fast_link_lamp_a: assert property (link_fast_lamp == (phy_link && phy_speed == 2'h1))
        else $error("fast link lamp wrong");
    gigabit_lamp_a: assert property (link_gigabit_lamp == (phy_link && phy_speed == 2'h2))
        else $error("gigabit lamp wrong");
    // registered enables get one cycle to drop after the cover opens
    cover_off_block_a: assert property (!safety_closed ##1 !safety_closed |-> !laser_enable && !disinfection_lamp)
        else $error("laser or uv on with cover off");
    pending_shows_a: assert property (unit_power_on && image_pending && !host_link_up |=> pending_indication && carrier_in)
        else $error("pending image not shown");
    step_advance_a: assert property (test_req && test_done && safety_closed && test_step < 4'h9 ##1 test_req
        |-> test_step == $past(test_step) + 4'h1)
        else $error("self-test step out of order");
    error_sticky_a: assert property (error_display && !power_key |=> error_display)
        else $error("error state left without restart");
    pending_keeps_on_a: assert property (unit_power_on && image_pending ##1 image_pending |-> unit_power_on)
        else $error("powered off with image pending");

    // main scenarios reached
    step_done_c: cover property (test_req && test_done);
    beep_c: cover property (beep);
    error_c: cover property (error_display);
endmodule : spmc_properties
`default_nettype wire

// File: spmc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module spmc_host_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // self-test handshake
    input  wire logic       test_req,
    input  wire logic [3:0] test_step,
    output logic            test_done,
    output logic            test_pass,
    // pace and order watch
    input  wire logic       slow,
    output logic            order_bad
);
    logic [2:0] wait_q;
    logic [4:0] last_q;
    // answer each step after a short or long wait; pass toggles when not valid
    always_ff @(posedge clk)
    begin
        test_done <= 1'b0;
        test_pass <= srst ? 1'b0 : ~test_pass;
        if (srst || !test_req)
        begin
            wait_q    <= 3'h0;
            last_q    <= 5'h1F;
            order_bad <= order_bad && !srst;
        end
        else if (!test_done)
        begin
            wait_q <= wait_q + 3'h1;
            if (wait_q == (slow ? 3'h6 : 3'h2))
            begin
                // steps may be skipped but never repeat or go back
                if (last_q != 5'h1F && {1'b0, test_step} <= last_q)
                    order_bad <= 1'b1;
                last_q    <= {1'b0, test_step};
                wait_q    <= 3'h0;
                test_done <= 1'b1;
                test_pass <= 1'b1;
            end
        end
    end
endmodule : spmc_host_model
`default_nettype wire

// File: spmc_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module spmc_top_test;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic        power_key = 1'b0, start_key = 1'b0, proximity = 1'b0, safety_closed = 1'b0;
    logic        host_link_up = 1'b0, image_pending = 1'b0, laser_req = 1'b0, uv_req = 1'b0;
    logic        uv_loop_closed = 1'b1, uv_current_ok = 1'b1, hv_supply_on = 1'b0;
    logic        fpga_in_reset = 1'b0, phy_link = 1'b0, slow = 1'b0;
    logic [1:0]  phy_speed = 2'h0;
    logic        pready, pslverr, test_req, test_done, test_pass, unit_power_on, beep;
    logic        carrier_in, pending_indication, error_display, laser_enable, disinfection_lamp;
    logic        uv_fault, high_voltage_lamp, logic_reset_lamp, link_slow_lamp, link_fast_lamp;
    logic        link_gigabit_lamp, order_bad, beeped, slverr_seen;
    logic [3:0]  test_step;
    logic [15:0] uv_remaining_s;
    int          mismatches = 0, checked = 0, n;

    // short second and key counts keep the run brief
    spmc_top #(.KEY_LONG_CYC(5), .KEY_ABORT_CYC(20), .SEC_CYC(10)) uut (.*);
    spmc_host_model host (.*);

    always #5 clk = ~clk;

    task automatic final_report;
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // a used-up bound is a failure and ends the run
    task automatic bound(input int cnt, input int lim);
        if (cnt >= lim)
        begin
            mismatches++;
            final_report();
        end
    endtask : bound

    // one apb transfer; an idle cycle follows so strobes never toggle twice in a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        bound(n, 50);
        rd_q        = prdata;
        slverr_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd_q & m);
    endtask : rd_chk

    // poll the state field until it shows the expected code
    task automatic wait_state(input spmc_pkg::spmc_state_t s);
        int k;
        for (k = 0; k < 150; k++)
        begin
            apb(1'b0, spmc_pkg::ADDR_STATUS, 32'h0);
            if (rd_q[7:0] === s)
                break;
        end
        chk("state", 32'(s), 32'(rd_q[7:0]));
        bound(k, 150);
    endtask : wait_state

    // hold one key for a count of cycles and note any beep
    task automatic press(input int k, input int cyc);
        beeped = 1'b0;
        case (k)
            0: power_key <= 1'b1;
            1: start_key <= 1'b1;
            default: proximity <= 1'b1;
        endcase
        repeat (cyc + 4)
        begin
            @(posedge clk);
            beeped |= beep;
            if (--cyc == 0)
            begin
                power_key <= 1'b0;
                start_key <= 1'b0;
                proximity <= 1'b0;
            end
        end
    endtask : press

    // power on; an open cover is closed while the erase lamp step runs
    task automatic power_up(input logic open);
        safety_closed <= !open;
        slow          <= open;
        press(0, 2);
        if (open)
        begin
            for (n = 0; n < 400 && test_step !== 4'h5; n++)
                @(posedge clk);
            bound(n, 400);
            safety_closed <= 1'b1;
        end
    endtask : power_up

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            phy_link      <= 1'b1;
            phy_speed     <= 2'(i);
            hv_supply_on  <= i[0];
            fpga_in_reset <= i[1];
            @(posedge clk);
            @(posedge clk);
            chk("link lamps", 32'(1 << i), 32'({link_gigabit_lamp, link_fast_lamp, link_slow_lamp}));
            chk("hv lamp", 32'(i[0]), 32'(high_voltage_lamp));
        end
        rd_chk("idle reset", spmc_pkg::ADDR_IDLE_S, 32'(spmc_pkg::IDLE_S_RST), 32'hFFFF);
        rd_chk("off reset", spmc_pkg::ADDR_OFF_S, 32'(spmc_pkg::OFF_S_RST), 32'hFFFF);
        rd_chk("unmapped", 12'h0F0, 32'h0, 32'hFFFFFFFF);
        chk("slverr", 32'h1, 32'(slverr_seen));
        apb(1'b1, spmc_pkg::ADDR_IDLE_S, 32'h4);
        apb(1'b1, spmc_pkg::ADDR_OFF_S, 32'h3);
        rd_chk("idle set", spmc_pkg::ADDR_IDLE_S, 32'h4, 32'hFFFF);
        power_up(1'b1);
        wait_state(spmc_pkg::ST_WAITLNK);
        chk("step order", 32'h0, 32'(order_bad));
        host_link_up <= 1'b1;
        wait_state(spmc_pkg::ST_READY);
        press(0, 2);
        chk("short press beep", 32'h1, 32'(beeped));
        wait_state(spmc_pkg::ST_READY);
        repeat (50) @(posedge clk);
        rd_chk("idle standby", spmc_pkg::ADDR_STATUS, 32'(spmc_pkg::ST_STANDBY), 32'hFF);
        press(2, 2);
        wait_state(spmc_pkg::ST_READY);
        repeat (50) @(posedge clk);
        apb(1'b1, spmc_pkg::ADDR_CTRL, 32'h3);
        wait_state(spmc_pkg::ST_READY);
        rd_chk("service ignored", spmc_pkg::ADDR_CTRL, 32'h0, 32'h2);
        apb(1'b1, spmc_pkg::ADDR_CTRL, 32'h3);
        rd_chk("service set", spmc_pkg::ADDR_CTRL, 32'h2, 32'h2);
        press(0, 8);
        chk("service power", 32'h1, 32'(unit_power_on));
        apb(1'b1, spmc_pkg::ADDR_CTRL, 32'h1);
        repeat (50) @(posedge clk);
        press(1, 2);
        wait_state(spmc_pkg::ST_READY);
        repeat (50) @(posedge clk);
        rd_chk("standby again", spmc_pkg::ADDR_STATUS, 32'(spmc_pkg::ST_STANDBY), 32'hFF);
        repeat (40) @(posedge clk);
        rd_chk("auto off", spmc_pkg::ADDR_STATUS, 32'(spmc_pkg::ST_OFF), 32'hFF);
        power_up(1'b0);
        wait_state(spmc_pkg::ST_READY);
        for (int j = 0; j < 2; j++)
        begin
            image_pending <= 1'b1;
            repeat (3) @(posedge clk);
            image_pending <= 1'b0;
            press(0, 8);
            wait_state(spmc_pkg::ST_UVCYC);
            chk("uv time shown", 32'h1, 32'(uv_remaining_s != 16'h0000));
            press(1 - j, 25);
            wait_state(j ? spmc_pkg::ST_OFF : spmc_pkg::ST_READY);
        end
        power_up(1'b0);
        wait_state(spmc_pkg::ST_READY);
        host_link_up  <= 1'b0;
        image_pending <= 1'b1;
        repeat (2) @(posedge clk);
        chk("pending shown", 32'h3, 32'({pending_indication, carrier_in}));
        press(0, 8);
        chk("pending beep", 32'h1, 32'(beeped));
        chk("pending power", 32'h1, 32'(unit_power_on));
        image_pending <= 1'b0;
        host_link_up  <= 1'b1;
        srst          <= 1'b1;
        repeat (3) @(posedge clk);
        srst      <= 1'b0;
        laser_req <= 1'b1;
        uv_req    <= 1'b1;
        power_up(1'b0);
        safety_closed <= 1'b0;
        for (n = 0; n < 400 && error_display !== 1'b1; n++)
            @(posedge clk);
        chk("error shown", 32'h1, 32'(error_display));
        chk("laser uv off", 32'h0, 32'({laser_enable, disinfection_lamp}));
        rd_chk("error state", spmc_pkg::ADDR_STATUS, 32'(spmc_pkg::ST_ERROR), 32'hFF);
        uv_loop_closed <= 1'b0;
        repeat (2) @(posedge clk);
        chk("uv fault", 32'h1, 32'(uv_fault));
        final_report();
    end

    // overall watchdog
    initial
    begin
        repeat (60000) @(posedge clk);
        bound(1, 1);
    end
endmodule : spmc_top_test

bind spmc_top spmc_properties chk_props (.*);
`default_nettype wire
